// [rtl/adc_sequencing_control.sv]
// Behaviour
// - Colliding result read is served before write.
// - Trigger edges ignored while a conversion runs.
// - Mode/select write beats completion's result write and interrupt, not a write deferred by a read.
// - Standby stops the converter.
// - Clearing the run bit stops conversion.
// - Mode writes never clear the done flag.
// - Completion hit by a mode write drops result and flag.
// - Completion colliding with stop keeps the old result.
// - Analog inputs double as bidirectional port pins.
// - Sample switch closed for first tenth.
// - Trigger mode converts once per external trigger.
// - Software mode converts back to back.
// - Mode rewrite with run aborts and restarts.
// - Conversion end latches result, raises interrupt.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
module adc_sequencing_control import adc_seq_pkg::*; #(
  parameter int SAMP_CYC = `SAMP_CYC,
  parameter int STEP_CYC = `STEP_CYC
) (
  input  wire logic       i_clk,                  // System clock, 10 MHz.
  input  wire logic       i_arst_n,               // Asynchronous reset, active low.
  input  wire logic       i_ce,                   // Clock enable, freezes all state except the reset synchronizer flops.
  input  wire logic [2:0] i_addr,                 // Register address.
  input  wire logic [7:0] i_wdata,                // Register write data.
  input  wire logic       i_wr,                   // Write strobe.
  input  wire logic       i_rd,                   // Read strobe.
  output logic      [7:0] o_rdata,                // Read data, cycle after strobe.
  input  wire logic       i_standby,              // Device standby request.
  input  wire logic       i_ext_trigger_input,    // External start trigger.
  input  wire logic       i_cmp,                  // Comparator: input at or above tap.
  input  wire logic [7:0] i_analog_input_pins,    // Pin levels in.
  output logic      [7:0] o_analog_input_pins,    // Port drive values.
  output logic      [7:0] o_analog_input_pins_oe, // Port drive enables.
  output logic      [2:0] o_ain_sel,              // Analog channel select.
  output logic            o_sample_sw,            // Sample switch closed.
  output logic      [7:0] o_sar_code,             // Trial code for the tap.
  output logic            o_converting,           // Conversion in progress.
  output logic            o_conversion_done_irq,  // One-cycle end pulse.
  output logic            o_conversion_done_flag  // Sticky done flag.
);
  localparam logic [7:0] SAMP_LAST = 8'(SAMP_CYC - 1);
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);

  // Decide bit idx from the comparator and arm the next lower trial bit.
  function automatic logic [7:0] sar_step(input logic [7:0] sar, input logic [2:0] idx,
                                          input logic cmp);
    logic [7:0] v;
    v = sar;
    v[idx] = cmp;
    if (idx != 3'h0) begin
      v[idx - 3'h1] = 1'b1;
    end
    return v;
  endfunction

  // Reset release through two flops; only rst_n_r is used below.
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  state_t     state_r;
  state_t     state_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] sar_r;
  logic [7:0] sar_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic [7:0] mode_r;
  logic [7:0] insel_r;
  logic [7:0] result_r;
  logic [7:0] pdata_r;
  logic [7:0] pdir_r;
  logic [7:0] pend_val_r;
  logic [7:0] rdata_r;
  logic [7:0] oe_r;
  logic       pend_r;
  logic       flag_r;
  logic       irq_r;
  logic       trig_d_r;
  logic       sample_r;
  logic       conv_r;

  // Register port decode.
  logic       wr_mode;
  logic       wr_insel;
  logic       wr_flag;
  logic       rd_result;
  logic [7:0] rd_mux;
  assign wr_mode   = i_wr && (i_addr == `ADDR_MODE);
  assign wr_insel  = i_wr && (i_addr == `ADDR_INSEL);
  assign wr_flag   = i_wr && (i_addr == `ADDR_FLAG);
  assign rd_result = i_rd && (i_addr == `ADDR_RESULT);
  assign rd_mux = (i_addr == `ADDR_MODE)   ? mode_r :
                  (i_addr == `ADDR_INSEL)  ? insel_r :
                  (i_addr == `ADDR_RESULT) ? result_r :
                  (i_addr == `ADDR_FLAG)   ? {7'h00, flag_r} :
                  (i_addr == `ADDR_PDATA)  ? i_analog_input_pins :
                  (i_addr == `ADDR_PDIR)   ? pdir_r : 8'h00;

  // Sequencer events.
  logic       run;
  logic       trigger_mode_bit;
  logic       trig_rise;
  logic       samp_end;
  logic       step_end;
  logic       done;
  logic       res_block;
  logic       res_defer;
  logic       res_we;
  logic [7:0] final_res;
  logic [7:0] res_val;
  assign run       = mode_r[`MODE_RUN_BIT];
  assign trigger_mode_bit       = mode_r[`MODE_TRG_BIT];
  assign trig_rise = i_ext_trigger_input && !trig_d_r;
  assign samp_end  = (state_r == ST_SAMPLE) && (cnt_r == SAMP_LAST);
  assign step_end  = (state_r == ST_CONV) && (cnt_r == STEP_LAST);
  assign done      = step_end && (bit_r == 3'h0);
  assign final_res = sar_step(sar_r, bit_r, i_cmp);
  // A stop landing on completion is a mode write, so the result is simply kept.
  assign res_block = wr_mode || wr_insel;
  // A read of the result defers the write so the read sees the old value.
  assign res_defer = done && rd_result && !res_block;
  assign res_we    = pend_r || (done && !res_block && !rd_result);
  assign res_val   = pend_r ? pend_val_r : final_res;

  // Next state: normal progress, then mode writes, then standby on top.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 8'h01;
    sar_nxt   = sar_r;
    bit_nxt   = bit_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 8'h00;
        if (run) begin
          state_nxt = trigger_mode_bit ? ST_WAIT : ST_SAMPLE;
        end
      end
      ST_WAIT: begin
        cnt_nxt = 8'h00;
        if (trig_rise) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (samp_end) begin
          state_nxt = ST_CONV;
          cnt_nxt   = 8'h00;
          sar_nxt   = `SAR_START;
          bit_nxt   = 3'h7;
        end
      end
      ST_CONV: begin
        if (step_end) begin
          cnt_nxt = 8'h00;
          sar_nxt = sar_step(sar_r, bit_r, i_cmp);
          if (bit_r == 3'h0) begin
            state_nxt = trigger_mode_bit ? ST_WAIT : ST_SAMPLE;
          end else begin
            bit_nxt = bit_r - 3'h1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (wr_mode) begin
      cnt_nxt = 8'h00;
      if (!i_wdata[`MODE_RUN_BIT]) begin
        state_nxt = ST_IDLE;
      end else begin
        state_nxt = i_wdata[`MODE_TRG_BIT] ? ST_WAIT : ST_SAMPLE;
      end
    end
    if (i_standby) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = 8'h00;
    end
  end

  // Sequencer flops.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 8'h00;
      sar_r    <= `REG_RST;
      bit_r    <= 3'h0;
      trig_d_r <= 1'b0;
      sample_r <= 1'b0;
      conv_r   <= 1'b0;
    end else if (i_ce) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      sar_r    <= sar_nxt;
      bit_r    <= bit_nxt;
      trig_d_r <= i_ext_trigger_input;
      sample_r <= (state_nxt == ST_SAMPLE);
      conv_r   <= (state_nxt == ST_SAMPLE) || (state_nxt == ST_CONV);
    end
  end

  // Software registers and result path.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r     <= `REG_RST;
      insel_r    <= `REG_RST;
      pdata_r    <= `REG_RST;
      pdir_r     <= `REG_RST;
      result_r   <= `REG_RST;
      pend_val_r <= `REG_RST;
      pend_r     <= 1'b0;
      flag_r     <= 1'b0;
      irq_r      <= 1'b0;
      rdata_r    <= 8'h00;
      oe_r       <= 8'h00;
    end else if (i_ce) begin
      if (wr_mode) begin
        mode_r <= i_wdata;
      end
      if (wr_insel) begin
        insel_r <= i_wdata;
      end
      if (i_wr && (i_addr == `ADDR_PDATA)) begin
        pdata_r <= i_wdata;
      end
      if (i_wr && (i_addr == `ADDR_PDIR)) begin
        pdir_r <= i_wdata;
      end
      if (res_we) begin
        result_r <= res_val;
      end
      if (res_defer) begin
        pend_val_r <= final_res;
      end
      pend_r  <= res_defer;
      irq_r   <= res_we;
      // Set wins over a clear in the same cycle, so no completion is lost.
      flag_r  <= res_we || (flag_r && !(wr_flag && i_wdata[`FLAG_BIT]));
      rdata_r <= i_rd ? rd_mux : 8'h00;
      // Pins chosen as analog inputs lose the port drive one cycle after insel_r changes.
      oe_r    <= pdir_r & ~insel_r;
    end
  end

  assign o_rdata                = rdata_r;
  assign o_analog_input_pins    = pdata_r;
  assign o_analog_input_pins_oe = oe_r;
  assign o_ain_sel              = mode_r[`MODE_CH_MSB:`MODE_CH_LSB];
  assign o_sample_sw            = sample_r;
  assign o_sar_code             = sar_r;
  assign o_converting           = conv_r;
  assign o_conversion_done_irq  = irq_r;
  assign o_conversion_done_flag = flag_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n_r);

  sequence s_deferred;
    pend_r ##1 irq_r;
  endsequence

  a_read_first: assert property (i_ce && res_defer |=> result_r == $past(result_r) ##0
    s_deferred)
    else $error("deferred result write not done in following cycle");
  a_trig_ignored: assert property (i_ce && state_r == ST_CONV && trig_rise && !done
    && !wr_mode && !i_standby |=> state_r == ST_CONV)
    else $error("trigger accepted during conversion");
  a_regwr_wins: assert property (i_ce && done && res_block |=> $stable(result_r)
    && !irq_r)
    else $error("result written despite register write");
  a_standby_stop: assert property (i_ce && i_standby && !wr_mode |=> state_r == ST_IDLE
    && $stable(mode_r[`MODE_RUN_BIT]))
    else $error("standby did not stop conversion");
  a_run_clear: assert property (i_ce && wr_mode && !i_wdata[`MODE_RUN_BIT]
    |=> state_r == ST_IDLE && !conv_r)
    else $error("clearing run bit did not stop");
  a_flag_keeps: assert property (i_ce && flag_r && wr_mode |=> flag_r)
    else $error("mode write cleared done flag");
  a_done_latch: assert property (i_ce && res_we |=> flag_r && irq_r
    && result_r == $past(res_val))
    else $error("conversion end not latched");
  a_sample_tenth: assert property (i_ce && samp_end && !wr_mode && !i_standby
    |=> !sample_r && state_r == ST_CONV)
    else $error("sample switch not opened after sampling");
  a_sample_len: assert property (sample_r |-> cnt_r <= SAMP_LAST)
    else $error("sampling longer than its share");
  a_trig_start: assert property (i_ce && state_r == ST_WAIT && trig_rise && !wr_mode
    && !i_standby |=> state_r == ST_SAMPLE && cnt_r == 8'h00)
    else $error("trigger did not start conversion");
  a_back_to_back: assert property (i_ce && done && !trigger_mode_bit && !wr_mode && !i_standby
    |=> state_r == ST_SAMPLE)
    else $error("software mode did not restart");
  a_restart: assert property (i_ce && wr_mode && i_wdata[`MODE_RUN_BIT]
    && !i_wdata[`MODE_TRG_BIT] && !i_standby |=> state_r == ST_SAMPLE && cnt_r == 8'h00)
    else $error("mode rewrite did not restart");
  a_pins_shared: assert property (|(o_analog_input_pins_oe & insel_r)
    |-> $changed(insel_r))
    else $error("analog input pin driven by port");
endmodule

// [rtl/adc_seq_defines.svh]
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
// Register addresses on the plain register port.
`define ADDR_MODE      3'h0
`define ADDR_INSEL     3'h1
`define ADDR_RESULT    3'h2
`define ADDR_FLAG      3'h3
`define ADDR_PDATA     3'h4
`define ADDR_PDIR      3'h5
// Field positions.
`define MODE_RUN_BIT   7
`define MODE_TRG_BIT   6
`define MODE_CH_MSB    3
`define MODE_CH_LSB    1
`define FLAG_BIT       0
// Reset values.
`define REG_RST        8'h00
`define SAR_START      8'h80
// Timing: conversion time in ns, clock period in ns, derived cycle counts.
`define CONV_TIME_NS   16000
`define CLK_PERIOD_NS  100
`define CONV_CYC       ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define SAMP_CYC       ((`CONV_CYC) / 10)
`define STEP_CYC       (((`CONV_CYC) - (`SAMP_CYC)) / 8)
`endif

// [rtl/adc_seq_pkg.sv]
package adc_seq_pkg;
  // Sequencer states: stopped, armed for a trigger, sampling, bit trials.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SAMPLE,
    ST_CONV
  } state_t;
endpackage

// [verif/tb_adc_sequencing_control.sv]
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
module tb_adc_sequencing_control;
  import adc_seq_pkg::*;
  // Short phases keep the run brief; every expectation below uses these values.
  localparam int SC = 2;
  localparam int TC = 2;
  logic       i_clk = 1'b0;
  logic       i_arst_n = 1'b0;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_standby = 1'b0;
  logic       i_ce = 1'b1;
  logic       i_ext_trigger_input = 1'b0;
  logic       i_cmp = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] pins = 8'h00;
  logic [7:0] o_rdata, o_analog_input_pins, o_analog_input_pins_oe, o_sar_code;
  logic [2:0] o_ain_sel;
  logic       o_sample_sw, o_converting, o_conversion_done_irq, o_conversion_done_flag;
  logic       rd_d = 1'b0;
  logic [7:0] vin, old;
  logic [7:0] exp_q[$];
  int         seed, failures = 0, n_checks = 0, n, p;

  always #50 i_clk = ~i_clk;

  adc_sequencing_control #(.SAMP_CYC(SC), .STEP_CYC(TC)) u_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_standby(i_standby),
    .i_ext_trigger_input(i_ext_trigger_input), .i_cmp(i_cmp), .i_analog_input_pins(pins),
    .o_analog_input_pins(o_analog_input_pins), .o_analog_input_pins_oe(o_analog_input_pins_oe),
    .o_ain_sel(o_ain_sel), .o_sample_sw(o_sample_sw), .o_sar_code(o_sar_code),
    .o_converting(o_converting), .o_conversion_done_irq(o_conversion_done_irq),
    .o_conversion_done_flag(o_conversion_done_flag));

  // The comparator acts as an ideal input at level vin; one cycle lag fits a two-cycle step.
  always @(posedge i_clk) i_cmp <= (vin >= o_sar_code);

  // Read data stands only in the cycle after the strobe, so it is taken off the queue there.
  always @(posedge i_clk) rd_d <= i_rd;
  always @(negedge i_clk) if (rd_d) check(o_rdata, exp_q.pop_front());

  task check(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // One bus cycle: a write, or a read whose expected value is queued.
  task op(input logic w, input logic [2:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= ~w;
    i_addr <= a;
    i_wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge i_clk);
  endtask

  task idle(input int k);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (k) @(posedge i_clk);
  endtask

  task wait_irq(output int c);
    c = 0;
    do begin
      @(negedge i_clk);
      c++;
    end while (o_conversion_done_irq !== 1'b1 && c < 400);
    if (c >= 400) begin
      failures++;
      $display("mismatch t=%0t no completion pulse", $time);
    end
  endtask

  // No completion pulse and, if asked, no conversion for k cycles.
  task quiet(input int k, input logic idle_conv);
    repeat (k) begin
      @(negedge i_clk);
      check({7'h00, o_conversion_done_irq}, 8'h00);
      if (idle_conv) check({7'h00, o_converting}, 8'h00);
    end
    @(posedge i_clk);
  endtask

  // Lines up the next bus cycle with the edge that would write a fresh result.
  task aim();
    wait_irq(n);
    wait_irq(p);
    old = vin;
    // The new level always differs from the old one, so a lost write is visible.
    vin = old ^ (8'($random(seed)) | 8'h01);
    @(posedge i_clk);
    repeat (p - 2) @(posedge i_clk);
  endtask

  task summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    failures++;
    summarize();
  end

  initial begin
    seed = 32'hF4964A39;
    vin = 8'($random(seed));
    pins = 8'($random(seed));
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    op(1'b0, `ADDR_MODE, 8'h00);
    op(1'b0, `ADDR_FLAG, 8'h00);
    idle(2);
    $display("test reset done");
    // Shared pins: analog-selected pins lose their drive enable.
    op(1'b1, `ADDR_PDATA, 8'hA5);
    op(1'b1, `ADDR_PDIR, 8'hFF);
    // A write with the clock enable low must leave the port data alone.
    i_ce <= 1'b0;
    op(1'b1, `ADDR_PDATA, 8'h5A);
    i_ce <= 1'b1;
    op(1'b1, `ADDR_INSEL, 8'h0F);
    op(1'b0, `ADDR_PDATA, pins);
    idle(3);
    check(o_analog_input_pins, 8'hA5);
    check(o_analog_input_pins_oe, 8'hF0);
    op(1'b1, `ADDR_INSEL, 8'h00);
    $display("test port pins done");
    // Software start on channel 5, repeated back to back.
    op(1'b1, `ADDR_MODE, 8'h8A);
    idle(0);
    wait_irq(n);
    vin = 8'($random(seed));
    wait_irq(p);
    check({7'h00, p <= SC + 8 * TC + 3}, 8'h01);
    check({5'h00, o_ain_sel}, 8'h05);
    @(posedge i_clk);
    op(1'b0, `ADDR_RESULT, vin);
    op(1'b0, `ADDR_FLAG, 8'h01);
    idle(1);
    $display("test software start done");
    // Result read colliding with the result write.
    aim();
    op(1'b0, `ADDR_RESULT, old);
    idle(0);
    wait_irq(n);
    check(8'(n), 8'h02);
    @(posedge i_clk);
    op(1'b0, `ADDR_RESULT, vin);
    idle(1);
    $display("test read collision done");
    // Select write colliding with the result write.
    aim();
    op(1'b1, `ADDR_INSEL, 8'h00);
    idle(0);
    quiet(4, 1'b0);
    op(1'b0, `ADDR_RESULT, old);
    idle(1);
    $display("test write collision done");
    // The flag survives a mode rewrite; the new channel is taken.
    op(1'b1, `ADDR_MODE, 8'h82);
    op(1'b0, `ADDR_FLAG, 8'h01);
    idle(2);
    check({5'h00, o_ain_sel}, 8'h01);
    op(1'b1, `ADDR_FLAG, 8'h01);
    op(1'b1, `ADDR_MODE, 8'h00);
    op(1'b0, `ADDR_FLAG, 8'h00);
    idle(1);
    quiet(40, 1'b1);
    $display("test stop done");
    // Trigger mode: one conversion per trigger, edges during conversion ignored.
    vin = 8'($random(seed));
    op(1'b1, `ADDR_MODE, 8'hC6);
    idle(1);
    quiet(10, 1'b1);
    check({5'h00, o_ain_sel}, 8'h03);
    i_ext_trigger_input <= 1'b1;
    idle(1);
    i_ext_trigger_input <= 1'b0;
    @(negedge i_clk);
    check({7'h00, o_sample_sw}, 8'h01);
    idle(6);
    i_ext_trigger_input <= 1'b1;
    idle(1);
    i_ext_trigger_input <= 1'b0;
    wait_irq(n);
    @(posedge i_clk);
    quiet(30, 1'b1);
    op(1'b0, `ADDR_RESULT, vin);
    idle(1);
    $display("test trigger mode done");
    // Standby aborts a running conversion and keeps the run bit.
    op(1'b1, `ADDR_MODE, 8'h80);
    idle(6);
    i_standby <= 1'b1;
    idle(2);
    quiet(30, 1'b1);
    op(1'b0, `ADDR_RESULT, vin);
    op(1'b0, `ADDR_MODE, 8'h80);
    idle(0);
    i_standby <= 1'b0;
    idle(3);
    check({7'h00, o_converting}, 8'h01);
    $display("test standby done");
    summarize();
  end
endmodule
